//--- adc_mode_channel_sequencer.sv
// Notes on behaviour
// - 8300h powers everything off at frame end
// - Pin wake restores defaults; software wake keeps
// - Power-off persists through hold frames
// - Idle states accept register access except under pin power-down; no data
// - Power-off exits at frame end on 8200h, A000h, a fixed code or a short frame
// - A000h starts the automatic ascending scan
// - Scan enabled channels ascending, wrap to lowest
// - Scan channel advances once per frame
// - Repeated A000h restarts from lowest channel
// - Automatic scan persists through hold frames
// - Unscanned channels may be powered down
// - Fixed channel sampled at next frame start
// - Fixed channel persists through hold frames
// - Mode switch applies at next frame start
// - Defaults command accepted in any scan mode
// - 8500h restores defaults, enters default state
// - No conversion after defaults until mode command
// - Software and pin power-down turn all analog off; only the pin blocks register access
// - Command is 16 bits, acted on after sixteenth
// - Fixed codes C000h step 0400h, E000h auxiliary
// - 8200h enters sleep with reference still on
// - All-zero command keeps the previous mode
`timescale 1ns/1ps
`default_nettype none
module adc_mode_channel_sequencer
    import seq_pkg::*;
(
    input  wire logic       sys_clk,         // 40 MHz system clock
    input  wire logic       reset_n,         // Asynchronous reset, active low
    input  wire logic       cs_n,            // Frame select, active low
    input  wire logic       sclk,            // Serial clock, sampled
    input  wire logic       sdi,             // Serial command data
    input  wire logic       reset_powerdown_pin_n, // Hardware power-down, active low
    input  wire logic [7:0] scan_enable_in,  // Scan-enable register write value
    input  wire logic       scan_enable_wr,  // Strobe for scan-enable write
    output logic      [7:0] scan_enable,     // Current scan-enable register
    output var  status_s    status,          // Power and channel state
    output logic            sdo_data_valid,  // High when frame data is a real conversion
    output logic            sample_strobe,   // Pulse at frame start when sampling
    output logic            prog_access_ok   // Register access allowed this frame
);

    mode_e      mode_reg,    mode_next;
    mode_e      pend_reg,    pend_next;
    logic [15:0] shift_reg,  shift_next;
    logic [5:0] bitcnt_reg,  bitcnt_next;
    logic [3:0] fix_reg,     fix_next;
    logic [3:0] pfix_reg,    pfix_next;
    logic [3:0] ch_reg,      ch_next;
    logic       restart_reg, restart_next;
    logic       pdef_reg,    pdef_next;
    logic [7:0] scan_reg,    scan_next;
    logic       cs_d_reg, sclk_d_reg, pin_d_reg;
    status_s    status_next;
    logic       sdv_next, strobe_next, prog_next;
    cmd_s       cmd;

    // Edge detection on inputs already synchronous to sys_clk
    wire cs_fall   = cs_d_reg && !cs_n;
    wire cs_rise   = !cs_d_reg && cs_n;
    wire sclk_fall = sclk_d_reg && !sclk && !cs_n;
    wire cmd_done  = (bitcnt_reg >= CMD_BITS);
    wire pin_wake  = !pin_d_reg && reset_powerdown_pin_n;
    wire pin_down  = !reset_powerdown_pin_n;

    cmd_decode u_dec (
        .word (shift_reg),
        .cmd  (cmd)
    );

    // Lowest enabled channel strictly above a start point, with wrap
    function automatic logic [3:0] next_enabled(input logic [7:0] en, input logic [3:0] from, input logic wrap);
        logic [3:0] r;
        logic       found;
        r     = CH_NONE;
        found = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (!found && en[i] && (wrap || (4'(i) > from))) begin
                r     = 4'(i);
                found = 1'b1;
            end
        end
        if (!found) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (!found && en[i]) begin
                    r     = 4'(i);
                    found = 1'b1;
                end
            end
        end
        return r;
    endfunction

    // Serial capture: bits land on sclk falling edges, only the first 16 count
    always_comb begin
        shift_next  = shift_reg;
        bitcnt_next = bitcnt_reg;
        if (cs_fall) begin
            bitcnt_next = '0;
        end else if (sclk_fall && (bitcnt_reg != '1)) begin            // Saturates, long frames never wrap
            bitcnt_next = bitcnt_reg + 6'h01;
            if (!cmd_done) begin
                shift_next = {shift_reg[14:0], sdi};
            end
        end
    end

    // Command acceptance at frame end; mode commands take hold at next frame start
    always_comb begin
        mode_next    = mode_reg;
        pend_next    = pend_reg;
        pfix_next    = pfix_reg;
        pdef_next    = pdef_reg;
        restart_next = restart_reg;
        fix_next     = fix_reg;
        ch_next      = ch_reg;
        scan_next    = scan_reg;
        if (scan_enable_wr) begin
            scan_next = scan_enable_in;
        end
        if (pin_down) begin
            mode_next = MODE_POWEROFF;
            pend_next = MODE_POWEROFF;
        end else if (pin_wake) begin
            mode_next = MODE_IDLE;
            pend_next = MODE_IDLE;
            scan_next = SCAN_DEFAULT;
        end else if (cs_rise) begin
            if (!cmd_done) begin
                mode_next = MODE_INVALID;                               // aborted frame
                pend_next = MODE_INVALID;
            end else if (cmd.poweroff) begin
                mode_next = MODE_POWEROFF;
                pend_next = MODE_POWEROFF;
            end else if (cmd.sleep) begin
                mode_next = MODE_SLEEP;
                pend_next = MODE_SLEEP;
            end else if (cmd.defaults) begin
                scan_next = SCAN_DEFAULT;
                pdef_next = 1'b1;
                pend_next = MODE_DEFAULTS;
            end else if (cmd.autoscan) begin
                pend_next    = MODE_AUTO;
                restart_next = 1'b1;
                if (mode_reg == MODE_POWEROFF) begin
                    mode_next = MODE_IDLE;
                end
            end else if (cmd.fixed) begin
                pend_next = MODE_FIXED;
                pfix_next = cmd.fix_ch;
                if (mode_reg == MODE_POWEROFF) begin
                    mode_next = MODE_IDLE;
                end
            end
            // Hold and unknown words leave everything as it is
        end else if (cs_fall) begin
            mode_next    = pend_reg;
            restart_next = 1'b0;
            pdef_next    = 1'b0;
            if (pend_reg == MODE_FIXED) begin
                fix_next = pfix_reg;
                ch_next  = pfix_reg;
            end else if (pend_reg == MODE_AUTO) begin
                if (restart_reg || (mode_reg != MODE_AUTO)) begin
                    ch_next = next_enabled(scan_reg, CH_NONE, 1'b1);
                end else begin
                    ch_next = next_enabled(scan_reg, ch_reg, 1'b0);
                end
            end else begin
                ch_next = CH_NONE;
            end
        end
    end

    // Analog-side status, registered so every output leaves a flip-flop
    wire converting_w = (mode_next == MODE_AUTO) || (mode_next == MODE_FIXED);
    always_comb begin
        status_next            = '0;
        status_next.all_off    = (mode_next == MODE_POWEROFF);
        status_next.ref_on     = (mode_next != MODE_POWEROFF);
        status_next.converting = converting_w && (ch_next != CH_NONE);
        status_next.channel    = ch_next;
        // Unscanned inputs are powered off in auto mode to save current
        status_next.ch_power   = (mode_next == MODE_AUTO) ? scan_next :
                                 (mode_next == MODE_POWEROFF) ? 8'h00 : 8'hFF;
        sdv_next    = status_next.converting;
        strobe_next = cs_fall && converting_w && (ch_next != CH_NONE);
        prog_next   = !pin_down;
    end

    // State registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_reg    <= MODE_IDLE;
            pend_reg    <= MODE_IDLE;
            shift_reg   <= '0;
            bitcnt_reg  <= '0;
            fix_reg     <= '0;
            pfix_reg    <= '0;
            ch_reg      <= CH_NONE;
            restart_reg <= 1'b0;
            pdef_reg    <= 1'b0;
            scan_reg    <= SCAN_DEFAULT;
            cs_d_reg    <= 1'b1;
            sclk_d_reg  <= 1'b0;
            pin_d_reg   <= 1'b1;
        end else begin
            mode_reg    <= mode_next;
            pend_reg    <= pend_next;
            shift_reg   <= shift_next;
            bitcnt_reg  <= bitcnt_next;
            fix_reg     <= fix_next;
            pfix_reg    <= pfix_next;
            ch_reg      <= ch_next;
            restart_reg <= restart_next;
            pdef_reg    <= pdef_next;
            scan_reg    <= scan_next;
            cs_d_reg    <= cs_n;
            sclk_d_reg  <= sclk;
            pin_d_reg   <= reset_powerdown_pin_n;
        end
    end

    // Output flops
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            status         <= '0;
            scan_enable    <= SCAN_DEFAULT;
            sdo_data_valid <= 1'b0;
            sample_strobe  <= 1'b0;
            prog_access_ok <= 1'b0;
        end else begin
            status         <= status_next;
            scan_enable    <= scan_next;
            sdo_data_valid <= sdv_next;
            sample_strobe  <= strobe_next;
            prog_access_ok <= prog_next;
        end
    end

    AST_POWEROFF_CMD: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (cs_rise && cmd_done && cmd.poweroff && !pin_down && !pin_wake)
        |=> (mode_reg == MODE_POWEROFF) ##1 status.all_off)
        else $error("power-off command not applied");
    AST_POWEROFF_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (mode_reg == MODE_POWEROFF && cs_rise && cmd_done && cmd.hold && !pin_wake) |=> (mode_reg == MODE_POWEROFF))
        else $error("power-off lost on hold frame");
    AST_AUTO_WRAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (cs_fall && pend_reg == MODE_AUTO && !pin_down && !pin_wake && (|scan_reg))
        |-> (ch_next != CH_NONE) && scan_reg[ch_next[2:0]])
        else $error("scan visits a disabled channel");
    AST_AUTO_RESTART: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (cs_fall && restart_reg && pend_reg == MODE_AUTO && !pin_down && !pin_wake)
        |=> (ch_reg == next_enabled($past(scan_reg), CH_NONE, 1'b1)))
        else $error("restart did not return to lowest channel");
    AST_FIXED_SAMPLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (cs_fall && pend_reg == MODE_FIXED && !pin_down && !pin_wake)
        |=> (ch_reg == $past(pfix_reg)) && sample_strobe ##1 !sample_strobe)
        else $error("fixed channel not applied at frame start");
    AST_NO_CONV_DEFAULTS: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (mode_reg == MODE_DEFAULTS) |-> !status.converting && !sdo_data_valid)
        else $error("conversion running in default state");
    // Defaults take hold at the frame start after the command, whatever mode ran before
    AST_DEFAULTS_MODE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (cs_fall && pdef_reg && pend_reg == MODE_DEFAULTS && !pin_down && !pin_wake)
        |=> (mode_reg == MODE_DEFAULTS) && (ch_reg == CH_NONE))
        else $error("defaults state not entered at frame start");
    AST_DEFAULTS_REGS: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (cs_rise && cmd_done && cmd.defaults && !pin_down && !pin_wake && !scan_enable_wr) |=> (scan_reg == SCAN_DEFAULT))
        else $error("defaults command did not restore registers");
    AST_PIN_WAKE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (pin_wake && !pin_down) |=> (scan_reg == SCAN_DEFAULT) && (mode_reg == MODE_IDLE))
        else $error("pin wake kept old settings");
    AST_SLEEP_REF: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (mode_reg == MODE_SLEEP) |-> status.ref_on)
        else $error("reference off in sleep");

endmodule
`default_nettype wire

//--- cmd_decode.sv
`timescale 1ns/1ps
`default_nettype none
module cmd_decode
    import seq_pkg::*;
(
    input  wire logic [15:0] word,   // Captured command word
    output var  cmd_s        cmd     // Decoded command
);

    wire       is_fix_ch = (word >= CMD_FIX_BASE) && (word <= CMD_FIX_LAST)
                           && (word[FIX_SHIFT-1:0] == FIX_LOW_ZERO);
    wire [2:0] fix_idx   = word[FIX_SHIFT+2:FIX_SHIFT];

    // Pure decode, unknown words decode to nothing
    always_comb begin
        cmd          = '0;
        cmd.hold     = (word == CMD_HOLD);
        cmd.sleep    = (word == CMD_SLEEP);
        cmd.poweroff = (word == CMD_POWEROFF);
        cmd.defaults = (word == CMD_DEFAULTS);
        cmd.autoscan = (word == CMD_AUTO);
        cmd.fixed    = is_fix_ch || (word == CMD_FIX_AUX);
        cmd.fix_ch   = is_fix_ch ? {1'b0, fix_idx} : CH_AUX;
    end

endmodule
`default_nettype wire

//--- host_frame_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_frame_model (
    input  wire logic        sys_clk, // System clock
    input  wire logic        req,     // Frame request, held until done
    input  wire logic [15:0] word,    // Command word
    input  wire logic [5:0]  nbits,   // Serial clocks in the frame
    output var  logic        cs_n,    // Frame select, active low
    output var  logic        sclk,    // Serial clock, still outside frames
    output var  logic        sdi,     // Serial data
    output var  logic        done     // Frame finished
);
    int i;

    // One frame per request; every change lands on a falling edge of sys_clk
    // Modes are judged here, not conversion data, so no reference warm-up is waited out
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi  = 1'b0;
        done = 1'b0;
        forever begin
            @(negedge sys_clk);
            if (req && !done) begin
                cs_n = 1'b0;
                repeat (2) @(negedge sys_clk);
                for (i = 0; i < nbits; i++) begin
                    // First 16 bits carry the command MSB first, later bits toggle
                    sdi  = (i < 16) ? word[15 - i] : ~sdi;
                    sclk = 1'b1;
                    repeat (2) @(negedge sys_clk);
                    sclk = 1'b0;
                    repeat (2) @(negedge sys_clk);
                end
                // Auto and fixed commands get 34-clock frames from the bench, except one 8-clock short frame
                cs_n = 1'b1;
                sdi  = ~sdi;  // Released line must not keep its last value
                repeat (4) @(negedge sys_clk);
                done = 1'b1;
            end else if (!req) begin
                done = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

//--- seq_pkg.sv
package seq_pkg;

    // Command words taken from the 16-bit command field
    localparam logic [15:0] CMD_HOLD     = 16'h0000;
    localparam logic [15:0] CMD_SLEEP    = 16'h8200;
    localparam logic [15:0] CMD_POWEROFF = 16'h8300;
    localparam logic [15:0] CMD_DEFAULTS = 16'h8500;
    localparam logic [15:0] CMD_AUTO     = 16'hA000;
    localparam logic [15:0] CMD_FIX_BASE = 16'hC000;
    localparam logic [15:0] CMD_FIX_LAST = 16'hDC00;
    localparam logic [15:0] CMD_FIX_AUX  = 16'hE000;
    localparam int          FIX_SHIFT    = 10;
    localparam logic [2:0]  FIX_TOP      = 3'h6;
    localparam logic [9:0]  FIX_LOW_ZERO = 10'h000;

    // Frame timing in serial clocks
    localparam logic [5:0]  CMD_BITS     = 6'h10;
    localparam logic [5:0]  PROG_BITS    = 6'h10;
    localparam logic [5:0]  DATA_BITS    = 6'h20;
    localparam logic [5:0]  PRIME_BITS   = 6'h22;

    // Channel count and defaults
    localparam int          NUM_CH       = 8;
    localparam logic [7:0]  SCAN_DEFAULT = 8'hFF;
    localparam logic [3:0]  CH_AUX       = 4'h8;
    localparam logic [3:0]  CH_NONE      = 4'hF;

    // Host warm-up time after power-off with the internal reference
    localparam int          WARM_MS      = 15;
    localparam int          CLK_KHZ      = 40000;
    localparam int          WARM_CYCLES  = WARM_MS * CLK_KHZ;

    typedef enum logic [2:0] {
        MODE_IDLE     = 3'b000,
        MODE_SLEEP    = 3'b001,
        MODE_POWEROFF = 3'b010,
        MODE_DEFAULTS = 3'b011,
        MODE_AUTO     = 3'b100,
        MODE_FIXED    = 3'b101,
        MODE_INVALID  = 3'b110
    } mode_e;

    // Decoded command word
    typedef struct packed {
        logic       hold;
        logic       sleep;
        logic       poweroff;
        logic       defaults;
        logic       autoscan;
        logic       fixed;
        logic [3:0] fix_ch;
    } cmd_s;

    // Power and channel state reported to the analog side
    typedef struct packed {
        logic       all_off;
        logic       ref_on;
        logic       converting;
        logic [3:0] channel;
        logic [7:0] ch_power;
    } status_s;

endpackage

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import seq_pkg::*;

    logic        sys_clk, reset_n, pin_n, req, done, cs_n, sclk, sdi, scan_wr;
    logic        sdo_data_valid, sample_strobe, prog_access_ok;
    logic [15:0] word;
    logic [5:0]  nbits;
    logic [7:0]  scan_in, scan_enable, en;
    logic [3:0]  exp_ch;
    status_s     status;
    int          num_errors, num_checks, strobes, k, i;

    adc_mode_channel_sequencer dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
        .reset_powerdown_pin_n(pin_n), .scan_enable_in(scan_in), .scan_enable_wr(scan_wr),
        .scan_enable(scan_enable), .status(status), .sdo_data_valid(sdo_data_valid),
        .sample_strobe(sample_strobe), .prog_access_ok(prog_access_ok));

    host_frame_model host_u (.sys_clk(sys_clk), .req(req), .word(word), .nbits(nbits), .cs_n(cs_n), .sclk(sclk),
        .sdi(sdi), .done(done));

    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;

    // Strobe pulses are counted so a single-cycle pulse is never missed
    always @(posedge sys_clk) begin
        if (reset_n !== 1'b1) strobes <= 0;
        else if (sample_strobe === 1'b1) strobes <= strobes + 1;
    end

    // Lowest enabled channel, none when the mask is empty
    function automatic logic [3:0] first_ch(input logic [7:0] e);
        for (int c = 0; c < NUM_CH; c++) if (e[c]) return 4'(c);
        return CH_NONE;
    endfunction

    // Next enabled channel above c, wrapping to the lowest
    function automatic logic [3:0] next_ch(input logic [7:0] e, input logic [3:0] c);
        for (int n = int'(c) + 1; n < NUM_CH; n++) if (e[n]) return 4'(n);
        return first_ch(e);
    endfunction

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic report_and_stop();
        if (num_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // One whole frame through the host model, waited for under a bound
    task automatic frame(input logic [15:0] w, input logic [5:0] n);
        int t;
        @(negedge sys_clk);
        word = w;
        nbits = n;
        req = 1'b1;
        for (t = 0; t < 400 && done !== 1'b1; t++) @(negedge sys_clk);
        if (done !== 1'b1) chk("frame done", 16'h0001, 16'h0000);
        req = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask

    task automatic scan_write(input logic [7:0] v);
        @(negedge sys_clk);
        scan_in = v;
        scan_wr = 1'b1;
        @(negedge sys_clk);
        scan_wr = 1'b0;
        @(negedge sys_clk);
    endtask

    // Hang guard sized well above the roughly 8k cycles of traffic
    initial begin
        repeat (60000) @(posedge sys_clk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        reset_n = 1'b0; pin_n = 1'b1; req = 1'b0; word = 16'h0000; nbits = 6'h00;
        scan_in = 8'h00; scan_wr = 1'b0; num_errors = 0; num_checks = 0;
        k = $urandom(87);
        repeat (12) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk("reset channel", 16'(CH_NONE), 16'(status.channel));
        chk("reset scan_enable", 16'(SCAN_DEFAULT), 16'(scan_enable));
        // Every fixed code, channels 0 to 7 and the auxiliary input
        for (i = 0; i < 9; i++) begin
            exp_ch = (i < 8) ? 4'(i) : CH_AUX;
            frame((i < 8) ? 16'hC000 + 16'h0400 * 16'(i) : 16'hE000, 6'h22);
            k = strobes;
            frame(CMD_HOLD, 6'h20);
            chk("fixed channel", 16'(exp_ch), 16'(status.channel));
            chk("fixed strobe", 16'(k + 1), 16'(strobes));
            frame(CMD_HOLD, 6'h20);
            chk("fixed kept", 16'(exp_ch), 16'(status.channel));
            chk("fixed valid", 16'h0001, 16'(sdo_data_valid));
        end
        // Top bit clear forms no defined code except the all-zero hold word
        frame(16'($urandom() & 32'h7FFF), 6'h20);
        frame(CMD_HOLD, 6'h20);
        chk("unknown word", 16'(CH_AUX), 16'(status.channel));
        frame(CMD_FIX_BASE, 6'h08);
        frame(CMD_HOLD, 6'h20);
        chk("short frame valid", 16'h0000, 16'(sdo_data_valid));
        // Automatic scan over a random nonzero mask, then a restart
        en = 8'($urandom_range(255, 1));
        scan_write(en);
        chk("scan write", 16'(en), 16'(scan_enable));
        frame(CMD_AUTO, 6'h22);
        exp_ch = first_ch(en);
        for (i = 0; i < 10; i++) begin
            frame(CMD_HOLD, 6'h20);
            chk("auto channel", 16'(exp_ch), 16'(status.channel));
            chk("auto power", 16'(en), 16'(status.ch_power));
            exp_ch = next_ch(en, exp_ch);
        end
        frame(CMD_AUTO, 6'h22);
        frame(CMD_HOLD, 6'h20);
        chk("auto restart", 16'(first_ch(en)), 16'(status.channel));
        frame(16'hC800, 6'h22);
        chk("switch pending", 16'(next_ch(en, first_ch(en))), 16'(status.channel));
        frame(CMD_HOLD, 6'h20);
        chk("switch applied", 16'h0002, 16'(status.channel));
        // Software power-off, register access while off, software wake
        frame(CMD_POWEROFF, 6'h10);
        chk("off all_off", 16'h0001, 16'(status.all_off));
        chk("off ref_on", 16'h0000, 16'(status.ref_on));
        frame(CMD_HOLD, 6'h20);
        chk("off kept", 16'h0001, 16'(status.all_off));
        chk("off power", 16'h0000, 16'(status.ch_power));
        chk("off valid", 16'h0000, 16'(sdo_data_valid));
        chk("off access", 16'h0001, 16'(prog_access_ok));
        scan_write(8'h5A);
        chk("off scan write", 16'h005A, 16'(scan_enable));
        frame(CMD_AUTO, 6'h22);
        chk("wake all_off", 16'h0000, 16'(status.all_off));
        chk("wake keeps regs", 16'h005A, 16'(scan_enable));
        frame(CMD_HOLD, 6'h20);
        chk("wake channel", 16'(first_ch(8'h5A)), 16'(status.channel));
        frame(CMD_SLEEP, 6'h10);
        chk("sleep ref_on", 16'h0001, 16'(status.ref_on));
        chk("sleep all_off", 16'h0000, 16'(status.all_off));
        chk("sleep valid", 16'h0000, 16'(sdo_data_valid));
        // Defaults from a fixed mode, then a conversion on defaults
        frame(CMD_FIX_BASE, 6'h22);
        frame(CMD_DEFAULTS, 6'h10);
        chk("defaults regs", 16'(SCAN_DEFAULT), 16'(scan_enable));
        frame(CMD_HOLD, 6'h20);
        chk("defaults valid", 16'h0000, 16'(sdo_data_valid));
        chk("defaults channel", 16'(CH_NONE), 16'(status.channel));
        frame(CMD_AUTO, 6'h22);
        frame(CMD_HOLD, 6'h20);
        chk("defaults scan", 16'(first_ch(SCAN_DEFAULT)), 16'(status.channel));
        // Pin power-down and its wake with defaults
        scan_write(8'h3C);
        pin_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk("pin all_off", 16'h0001, 16'(status.all_off));
        chk("pin access", 16'h0000, 16'(prog_access_ok));
        pin_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk("pin wake regs", 16'(SCAN_DEFAULT), 16'(scan_enable));
        report_and_stop();
    end
endmodule
`default_nettype wire
